// ===== src/pll_ctrl_pkg.sv
// Package: register map, field layout, reset values and calibration timing of the PLL control block
`default_nettype none

package pll_ctrl_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register byte addresses
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 32;
    localparam logic [7:0]  OFS_PLL2_M_DIV  = 8'h34;
    localparam logic [7:0]  OFS_PLL1_CTRL   = 8'h38;
    localparam logic [7:0]  OFS_PLL1_STATUS = 8'h3c;

    // ------------------------------------------------------------------
    // Field widths, status layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_W          = 5;
    localparam int unsigned PRE_DIV_W       = 5;
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_RATIO_LSB  = 3;
    localparam logic [2:0]  POST_DIV_RST    = 3'h7;
    localparam logic        RESYNC_EN_RST   = 1'b1;
    localparam logic        POWER_DOWN_RST  = 1'b0;
    localparam logic [4:0]  PRE_DIV_RST     = 5'h00;

    // ------------------------------------------------------------------
    // Calibration timing: least time, rounded up to whole cycles
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned CAL_TIME_NS     = 1000;
    localparam int unsigned CAL_CYCLES      = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Control zero layout: bits [4:2] post divider, [1] resync enable, [0] power down
    typedef struct packed {
        logic [2:0] first_pll_post_divider;
        logic       first_pll_resync_enable;
        logic       first_pll_power_down;
    } first_pll_control_zero_t;

    // Calibration sequencer states, one-hot
    typedef enum logic [2:0] {
        CAL_OFF  = 3'b001,
        CAL_RUN  = 3'b010,
        CAL_LOCK = 3'b100
    } cal_state_t;

    // Post divider: codes 0 and 1 both divide by two
    function automatic logic [3:0] post_ratio_f(input logic [2:0] code);
        post_ratio_f = (code < 3'h2) ? 4'h2 : ({1'b0, code} + 4'h1);
    endfunction

    // Pre divider: code 0 bypasses (ratio 1), otherwise code plus one
    function automatic logic [5:0] pre_ratio_f(input logic [4:0] code);
        pre_ratio_f = (code == 5'h00) ? 6'h01 : ({1'b0, code} + 6'h01);
    endfunction

endpackage

`default_nettype wire

// ===== src/sync_rise_detect.sv
// Two-flop synchroniser with a one-cycle rising-edge pulse
`default_nettype none

module sync_rise_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level_q,
    output logic      rise_q
);

    logic meta_q;
    logic past_q;

    // ------------------------------------------------------------------
    // Synchroniser: the first stage feeds only the second stage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q  <= async_in;
            level_q <= meta_q;
        end
    end

    // Edge detect works on the settled level only
    always_ff @(posedge clk) begin
        if (rst) begin
            past_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            past_q <= level_q;
            rise_q <= level_q & ~past_q;
        end
    end

endmodule // sync_rise_detect

`default_nettype wire

// ===== src/pll_cal_sequencer.sv
// Power and calibration sequencer of the first PLL
`default_nettype none

module pll_cal_sequencer
    import pll_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES = CAL_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic power_down,
    output cal_state_t state_q,
    output logic      pll_enable_q,
    output logic      cal_reset_q,
    output logic      cal_start_q
);

    localparam int unsigned CNT_W = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_bad_cycles
        $error("Calibration needs at least one cycle");
    end

    cal_state_t       state_d;
    logic [CNT_W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Next state: power down always wins over a running calibration
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            CAL_OFF:  if (!power_down) state_d = CAL_RUN;
            CAL_RUN: begin
                if (power_down) begin
                    state_d = CAL_OFF;
                end else if (cnt_q == '0) begin
                    state_d = CAL_LOCK;
                end
            end
            CAL_LOCK: if (power_down) state_d = CAL_OFF;
            default:  state_d = CAL_OFF;
        endcase
    end

    // State and registered PLL controls, taken from the next state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q      <= CAL_OFF;
            pll_enable_q <= 1'b0;
            cal_reset_q  <= 1'b1;
            cal_start_q  <= 1'b0;
        end else begin
            state_q      <= state_d;
            pll_enable_q <= (state_d != CAL_OFF);
            cal_reset_q  <= (state_d == CAL_OFF);
            cal_start_q  <= (state_d == CAL_RUN) && (state_q != CAL_RUN);
        end
    end

    // Calibration timer, reloaded on every fresh start
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (state_q == CAL_OFF) begin
            cnt_q <= CNT_W'(CYCLES - 1);
        end else if (state_q == CAL_RUN && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule // pll_cal_sequencer

`default_nettype wire

// ===== src/pll_divider_power_control.sv
// Divider and power-down control registers of a dual-PLL clock generator
`default_nettype none

module pll_divider_power_control
    import pll_ctrl_pkg::*;
(
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST,
    // Wishbone classic slave
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    input  wire logic                    WB_WE_I,
    input  wire logic [ADDR_W-1:0]       WB_ADR_I,
    input  wire logic [3:0]              WB_SEL_I,
    input  wire logic [DATA_W-1:0]       WB_DAT_I,
    output logic      [DATA_W-1:0]       WB_DAT_O,
    output logic                         WB_ACK_O,
    // EEPROM image load, same clock domain
    input  wire logic                    EE_LOAD,
    input  var  first_pll_control_zero_t EE_PLL1_CTRL,
    input  wire logic [PRE_DIV_W-1:0]    EE_PLL2_PRE_DIV,
    // Sync event pin
    input  wire logic                    SYNC_IN,
    // Controls to the analog PLLs and channels
    output logic [3:0]                   PLL1_POST_RATIO,
    output logic [5:0]                   PLL2_PRE_RATIO,
    output logic                         PLL2_PRE_BYPASS,
    output logic                         PLL1_ENABLE,
    output logic                         PLL1_CAL_RESET,
    output logic                         PLL1_CAL_START,
    output logic                         PLL1_RESYNC
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    first_pll_control_zero_t first_pll_control_zero_q;
    logic [PRE_DIV_W-1:0]    second_pll_pre_divider_q;
    logic                    ack_q;
    logic                    wb_req;
    logic                    wr_fire;
    logic                    wr_ctrl;
    logic                    wr_pre;
    logic [DATA_W-1:0]       rd_data;
    cal_state_t              cal_state;
    logic                    sync_level;
    logic                    sync_rise;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------

    // A request is answered one cycle after it appears; the write lands on the ack edge
    assign wb_req  = WB_CYC_I & WB_STB_I;
    assign wr_fire = wb_req & ack_q & WB_WE_I & WB_SEL_I[0];
    assign wr_ctrl = wr_fire && (WB_ADR_I == OFS_PLL1_CTRL);
    assign wr_pre  = wr_fire && (WB_ADR_I == OFS_PLL2_M_DIV);

    // Ack toggles off after one cycle so a held request is not answered in two cycles in a row
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req & ~ack_q;
        end
    end

    // Read mux; unmapped addresses answer with zero
    always_comb begin
        rd_data = '0;
        if (WB_ADR_I == OFS_PLL1_CTRL) begin
            rd_data[CTRL_W-1:0] = first_pll_control_zero_q;
        end else if (WB_ADR_I == OFS_PLL2_M_DIV) begin
            rd_data[PRE_DIV_W-1:0] = second_pll_pre_divider_q;
        end else if (WB_ADR_I == OFS_PLL1_STATUS) begin
            rd_data[STAT_STATE_LSB +: 3] = cal_state;
            rd_data[STAT_RATIO_LSB +: 4] = PLL1_POST_RATIO;
        end
    end

    // Read data is captured with the ack and cleared otherwise
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WB_DAT_O <= '0;
        end else if (wb_req && !ack_q && !WB_WE_I) begin
            WB_DAT_O <= rd_data;
        end else begin
            WB_DAT_O <= '0;
        end
    end

    assign WB_ACK_O = ack_q;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------

    // Only the defined low bits are stored, so the upper bits stay zero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            first_pll_control_zero_q.first_pll_post_divider  <= POST_DIV_RST;
            first_pll_control_zero_q.first_pll_resync_enable <= RESYNC_EN_RST;
            first_pll_control_zero_q.first_pll_power_down    <= POWER_DOWN_RST;
        end else if (EE_LOAD) begin
            first_pll_control_zero_q <= EE_PLL1_CTRL;
        end else if (wr_ctrl) begin
            first_pll_control_zero_q <= WB_DAT_I[CTRL_W-1:0];
        end
    end

    // Pre divider shares the EEPROM load so both PLLs come up together
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            second_pll_pre_divider_q <= PRE_DIV_RST;
        end else if (EE_LOAD) begin
            second_pll_pre_divider_q <= EE_PLL2_PRE_DIV;
        end else if (wr_pre) begin
            second_pll_pre_divider_q <= WB_DAT_I[PRE_DIV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Divider ratio outputs
    // ------------------------------------------------------------------

    // Registered so the analog side never sees decode glitches
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PLL1_POST_RATIO <= post_ratio_f(POST_DIV_RST);
            PLL2_PRE_RATIO  <= pre_ratio_f(PRE_DIV_RST);
            PLL2_PRE_BYPASS <= 1'b1;
        end else begin
            PLL1_POST_RATIO <= post_ratio_f(first_pll_control_zero_q.first_pll_post_divider);
            PLL2_PRE_RATIO  <= pre_ratio_f(second_pll_pre_divider_q);
            PLL2_PRE_BYPASS <= (second_pll_pre_divider_q == 5'h00);
        end
    end

    // ------------------------------------------------------------------
    // Power down and calibration
    // ------------------------------------------------------------------

    // Sequencer restarts calibration on every release of power down
    pll_cal_sequencer #(
        .CYCLES       (CAL_CYCLES)
    ) u_cal (
        .clk          (CORE_CLK),
        .rst          (RST),
        .power_down   (first_pll_control_zero_q.first_pll_power_down),
        .state_q      (cal_state),
        .pll_enable_q (PLL1_ENABLE),
        .cal_reset_q  (PLL1_CAL_RESET),
        .cal_start_q  (PLL1_CAL_START)
    );

    // ------------------------------------------------------------------
    // Sync event handling
    // ------------------------------------------------------------------

    // The pin is asynchronous; a short glitch below one cycle may be missed
    sync_rise_detect u_sync (
        .clk      (CORE_CLK),
        .rst      (RST),
        .async_in (SYNC_IN),
        .level_q  (sync_level),
        .rise_q   (sync_rise)
    );

    // One-cycle resync pulse, gated by the enable bit
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PLL1_RESYNC <= 1'b0;
        end else begin
            PLL1_RESYNC <= sync_rise & first_pll_control_zero_q.first_pll_resync_enable;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    chk_pre_max_ratio: assert property (
        wr_pre && !EE_LOAD && WB_DAT_I[4:0] == 5'h1f |=> ##1 PLL2_PRE_RATIO == 6'h20 && !PLL2_PRE_BYPASS)
        else $error("Pre divider code 31 did not give ratio 32");

    chk_pre_bypass_code: assert property (
        wr_pre && !EE_LOAD && WB_DAT_I[4:0] == 5'h00 |=> ##1 PLL2_PRE_BYPASS && PLL2_PRE_RATIO == 6'h01)
        else $error("Pre divider code 0 did not bypass");

    chk_post_low_codes: assert property (
        wr_ctrl && !EE_LOAD && WB_DAT_I[4:3] == 2'b00 |=> ##1 PLL1_POST_RATIO == 4'h2)
        else $error("Post divider code 0 or 1 did not give ratio 2");

    chk_post_reset_code: assert property (disable iff (1'b0)
        $past(RST) |-> first_pll_control_zero_q.first_pll_post_divider == 3'h7
                    && first_pll_control_zero_q.first_pll_resync_enable)
        else $error("Control reset values wrong");

    chk_resync_gating: assert property (
        sync_rise |=> PLL1_RESYNC == $past(first_pll_control_zero_q.first_pll_resync_enable))
        else $error("Resync pulse not gated by the enable bit");

    chk_boot_calibrate: assert property (disable iff (1'b0)
        $fell(RST) && !first_pll_control_zero_q.first_pll_power_down && !EE_LOAD
        |-> ##[0:1] PLL1_CAL_START ##1 PLL1_ENABLE && !PLL1_CAL_RESET)
        else $error("No calibration after reset");

    chk_pdn_disables: assert property (
        first_pll_control_zero_q.first_pll_power_down |=> !PLL1_ENABLE && PLL1_CAL_RESET)
        else $error("Power down did not disable the PLL");

    chk_restart_cal: assert property (
        $fell(first_pll_control_zero_q.first_pll_power_down) |-> ##1 PLL1_CAL_START && PLL1_ENABLE)
        else $error("Calibration not restarted after power down release");

    chk_eeprom_load: assert property (
        EE_LOAD |=> first_pll_control_zero_q == $past(EE_PLL1_CTRL)
                    && second_pll_pre_divider_q == $past(EE_PLL2_PRE_DIV))
        else $error("EEPROM image not loaded");

    chk_reserved_zero: assert property (
        WB_ACK_O |-> WB_DAT_O[DATA_W-1:7] == '0)
        else $error("Reserved read bits not zero");

    chk_ack_one_cycle: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("Ack held longer than one cycle");

    // Bus answer timing: exactly one cycle after a fresh request, never unasked
    chk_ack_answer: assert property (
        wb_req && !WB_ACK_O |=> WB_ACK_O)
        else $error("Request not answered in the next cycle");

    chk_ack_no_stray: assert property (
        !wb_req |=> !WB_ACK_O)
        else $error("Ack without a request");

    // Read data stands only with the ack, so a late sample never sees stale data
    chk_idle_data_zero: assert property (
        !WB_ACK_O |-> WB_DAT_O == '0)
        else $error("Read data not zero outside the ack cycle");

    // Pre divider codes 1 to 31 and post divider codes 2 to 7, not just the end points
    chk_pre_any_code: assert property (
        wr_pre && !EE_LOAD && WB_DAT_I[4:0] != 5'h00
        |=> ##1 PLL2_PRE_RATIO == {1'b0, $past(WB_DAT_I[4:0], 2)} + 6'h01 && !PLL2_PRE_BYPASS)
        else $error("Pre divider ratio is not code plus one");

    chk_post_any_code: assert property (
        wr_ctrl && !EE_LOAD && WB_DAT_I[4:3] != 2'b00
        |=> ##1 PLL1_POST_RATIO == {1'b0, $past(WB_DAT_I[4:2], 2)} + 4'h1)
        else $error("Post divider ratio is not code plus one");

    // Writes store the defined bits and nothing else
    chk_ctrl_write_lands: assert property (
        wr_ctrl && !EE_LOAD |=> first_pll_control_zero_q == $past(WB_DAT_I[CTRL_W-1:0]))
        else $error("Control write did not store the defined bits");

    chk_pre_write_lands: assert property (
        wr_pre && !EE_LOAD |=> second_pll_pre_divider_q == $past(WB_DAT_I[PRE_DIV_W-1:0]))
        else $error("Pre divider write did not store the defined bits");

    // Power down written on the bus reaches the PLL two edges later
    chk_pdn_write_off: assert property (
        wr_ctrl && !EE_LOAD && WB_DAT_I[0] |=> ##1 !PLL1_ENABLE && PLL1_CAL_RESET && !PLL1_CAL_START)
        else $error("Power down write did not stop the PLL");

    chk_cal_release: assert property (
        $fell(first_pll_control_zero_q.first_pll_power_down) |-> ##1 !PLL1_CAL_RESET)
        else $error("Calibration reset not released after power down cleared");

    chk_start_pulse: assert property (
        PLL1_CAL_START |=> !PLL1_CAL_START)
        else $error("Calibration start longer than one cycle");

    // Resync pulse: blocked while disabled, one cycle when it fires
    chk_resync_blocked: assert property (
        !first_pll_control_zero_q.first_pll_resync_enable |=> !PLL1_RESYNC)
        else $error("Resync pulse while the enable bit is clear");

    chk_resync_pulse: assert property (
        PLL1_RESYNC |=> !PLL1_RESYNC)
        else $error("Resync pulse longer than one cycle");

    // ------------------------------------------------------------------
    // Scenario covers
    // ------------------------------------------------------------------
    cov_calibration_lock: cover property (
        PLL1_CAL_START ##[1:200] cal_state == CAL_LOCK);

    cov_pdn_cycle: cover property (
        first_pll_control_zero_q.first_pll_power_down ##[1:50] PLL1_CAL_START);

    cov_resync_pulse: cover property (
        sync_level ##[0:4] PLL1_RESYNC);

    cov_sel_dropped: cover property (
        wb_req && WB_ACK_O && WB_WE_I && !WB_SEL_I[0]);

    cov_ee_load: cover property (
        EE_LOAD ##2 PLL2_PRE_RATIO != 6'h01);

endmodule // pll_divider_power_control

`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking testbench of the PLL divider and power-down control block
`default_nettype none

module tb_top
    import pll_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]              adr = 8'h00;
    logic [3:0]              sel = 4'h0;
    logic [31:0]             dat_i = 32'h0, dat_o;
    logic                    ack;
    logic                    ee_load = 1'b0;
    first_pll_control_zero_t ee_ctrl = '0;
    logic [4:0]              ee_pre = 5'h00;
    logic                    sync_pin = 1'b0;
    logic [3:0]              post_ratio;
    logic [5:0]              pre_ratio;
    logic                    pre_bypass, pll_en, cal_rst, cal_start, resync;
    int                      fails = 0, total_checks = 0, n_start = 0, n_resync = 0;
    logic [31:0]             rd;

    pll_divider_power_control u_pll_divider_power_control (
        .CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .EE_LOAD(ee_load),
        .EE_PLL1_CTRL(ee_ctrl), .EE_PLL2_PRE_DIV(ee_pre), .SYNC_IN(sync_pin),
        .PLL1_POST_RATIO(post_ratio), .PLL2_PRE_RATIO(pre_ratio), .PLL2_PRE_BYPASS(pre_bypass),
        .PLL1_ENABLE(pll_en), .PLL1_CAL_RESET(cal_rst), .PLL1_CAL_START(cal_start), .PLL1_RESYNC(resync)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // Pulse counters, so one-cycle strobes are never missed by a late sample
    always @(posedge clk) begin
        if (cal_start === 1'b1) n_start <= n_start + 1;
        if (resync === 1'b1) n_resync <= n_resync + 1;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single cycle; entered just after a rising edge, data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= d; sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20) begin
            fails++;
            $display("BAD bus ack expected 1 seen timeout");
            conclude();
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check("post ratio rst", {28'h0, post_ratio}, 32'h8);
        check("pre bypass rst", {31'h0, pre_bypass}, 32'h1);
        check("cal reset rst", {31'h0, cal_rst}, 32'h1);
        rst <= 1'b0;
        settle();
        check("start after rst", n_start, 1);
        check("enable after rst", {31'h0, pll_en}, 32'h1);
        wb(1'b0, 8'h38, 32'h0, 4'hf, rd);
        check("ctrl rst", rd, 32'h1e);
        wb(1'b0, 8'h34, 32'h0, 4'hf, rd);
        check("pre rst", rd, 32'h0);
        repeat (140) @(posedge clk);
        wb(1'b0, 8'h3c, 32'h0, 4'hf, rd);
        check("locked status", rd, {25'h0, 4'h8, 3'b100});
        $display("reset test done");
    endtask

    task automatic t_pre();
        logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h1e, 5'h1f};
        foreach (codes[i]) begin
            wb(1'b1, 8'h34, {27'h7ffffff, codes[i]}, 4'hf, rd);
            settle();
            check("pre ratio", {26'h0, pre_ratio}, (codes[i] == 5'h00) ? 32'h1 : codes[i] + 32'h1);
            check("pre bypass", {31'h0, pre_bypass}, {31'h0, codes[i] == 5'h00});
            wb(1'b0, 8'h34, 32'h0, 4'hf, rd);
            check("pre readback", rd, {27'h0, codes[i]});
        end
        // A write without the low byte lane selected is dropped
        wb(1'b1, 8'h34, 32'h05, 4'he, rd);
        wb(1'b0, 8'h34, 32'h0, 4'hf, rd);
        check("pre sel drop", rd, 32'h1f);
        wb(1'b0, 8'h40, 32'h0, 4'hf, rd);
        check("unmapped read", rd, 32'h0);
        $display("pre divider test done");
    endtask

    task automatic t_post();
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, 8'h38, {27'h0, c[2:0], 2'b10}, 4'hf, rd);
            settle();
            check("post ratio", {28'h0, post_ratio}, (c < 2) ? 32'h2 : c + 1);
        end
        $display("post divider test done");
    endtask

    task automatic t_power();
        int s0;
        wb(1'b1, 8'h38, 32'h1f, 4'hf, rd);
        settle();
        check("enable off", {31'h0, pll_en}, 32'h0);
        check("cal held", {31'h0, cal_rst}, 32'h1);
        wb(1'b0, 8'h3c, 32'h0, 4'hf, rd);
        check("off status", {29'h0, rd[2:0]}, 32'h1);
        s0 = n_start;
        settle();
        check("no start while off", n_start, s0);
        wb(1'b1, 8'h38, 32'h1e, 4'hf, rd);
        settle();
        check("restart", n_start, s0 + 1);
        check("enable on", {31'h0, pll_en}, 32'h1);
        check("cal released", {31'h0, cal_rst}, 32'h0);
        $display("power test done");
    endtask

    task automatic pulse_sync(input int exp_delta);
        int r0;
        r0 = n_resync;
        sync_pin <= 1'b1;
        repeat (3) @(posedge clk);
        sync_pin <= 1'b0;
        repeat (8) @(posedge clk);
        check("resync pulses", n_resync, r0 + exp_delta);
    endtask

    task automatic t_sync();
        wb(1'b1, 8'h38, 32'h1e, 4'hf, rd);
        pulse_sync(1);
        // Reserved bits written high must not stick; resync turned off here
        wb(1'b1, 8'h38, 32'hffffffdc, 4'hf, rd);
        wb(1'b0, 8'h38, 32'h0, 4'hf, rd);
        check("ctrl reserved", rd, 32'h1c);
        pulse_sync(0);
        $display("sync test done");
    endtask

    task automatic t_eeprom();
        ee_ctrl <= first_pll_control_zero_t'(5'h0a);
        ee_pre <= 5'h0a;
        ee_load <= 1'b1;
        @(posedge clk) ee_load <= 1'b0;
        settle();
        wb(1'b0, 8'h38, 32'h0, 4'hf, rd);
        check("ee ctrl", rd, 32'h0a);
        wb(1'b0, 8'h34, 32'h0, 4'hf, rd);
        check("ee pre", rd, 32'h0a);
        check("ee post ratio", {28'h0, post_ratio}, 32'h3);
        check("ee pre ratio", {26'h0, pre_ratio}, 32'hb);
        $display("eeprom test done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence: reset held four cycles, then the scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        t_reset();
        t_pre();
        t_post();
        t_power();
        t_sync();
        t_eeprom();
        conclude();
    end
endmodule // tb_top

`default_nettype wire
